/* include/cam_regs_pkg.sv */
package cam_regs_pkg;

    localparam int unsigned      ADDR_W          = 16;
    localparam int unsigned      DATA_W          = 16;

    // Register offsets
    localparam logic [15:0]      OFS_CONTROL     = 16'h0001;
    localparam logic [15:0]      OFS_STATUS      = 16'h0003;
    localparam logic [15:0]      OFS_LAYOUT      = 16'h0004;
    localparam logic [15:0]      OFS_EXPOSURE    = 16'h0005;
    localparam logic [15:0]      OFS_HW_ID       = 16'h0006;
    localparam logic [15:0]      OFS_REVISION    = 16'h0008;
    localparam logic [15:0]      OFS_MOD_INDEX   = 16'h0009;
    localparam logic [15:0]      OFS_RATE        = 16'h000a;
    localparam logic [15:0]      OFS_LENS        = 16'h000b;
    localparam logic [15:0]      OFS_SERIAL_LO   = 16'h000c;
    localparam logic [15:0]      OFS_SERIAL_HI   = 16'h000d;
    localparam logic [15:0]      OFS_TALLY       = 16'h000e;
    localparam logic [15:0]      OFS_UNLOCK      = 16'h0022;

    // Reset values
    localparam logic [15:0]      RST_CONTROL     = 16'h0001;
    localparam logic [15:0]      RST_STATUS      = 16'h0040;
    localparam logic [15:0]      RST_LAYOUT      = 16'h0000;
    localparam logic [15:0]      RST_EXPOSURE    = 16'h01f4;
    localparam logic [15:0]      RST_MOD_INDEX   = 16'h08ca;
    localparam logic [15:0]      RST_RATE        = 16'h0019;
    localparam logic [15:0]      RST_LENS        = 16'h005a;
    localparam logic [15:0]      RST_UNLOCK      = 16'h0000;
    localparam logic [15:0]      RST_TALLY       = 16'h0000;

    // Control word bits
    localparam int unsigned      CTL_VIDEO       = 0;
    localparam int unsigned      CTL_TRIGGER     = 4;
    localparam int unsigned      CTL_CLR_STATUS  = 6;
    localparam int unsigned      CTL_BOOT        = 8;
    localparam int unsigned      CTL_BOOT_NET    = 12;
    localparam logic [15:0]      BOOT_KEY        = 16'h5e6b;

    // Status word bits
    localparam int unsigned      ST_BOOTLOADER   = 0;
    localparam int unsigned      ST_CALIB_BUSY   = 2;
    localparam int unsigned      ST_LED_SENS     = 3;
    localparam int unsigned      ST_MAIN_SENS    = 4;
    localparam int unsigned      ST_CALIB_MISS   = 5;
    localparam int unsigned      ST_FACTORY_MAP  = 6;
    localparam int unsigned      ST_LED_OVERTEMP = 9;
    localparam int unsigned      ST_BASE_SENS    = 14;

    // Layout field and codes
    localparam int unsigned      LAYOUT_LSB      = 3;
    localparam int unsigned      LAYOUT_W        = 8;
    localparam logic [7:0]       LAY_DEPTH_AMP   = 8'h00;
    localparam logic [7:0]       LAY_XYZ         = 8'h03;
    localparam logic [7:0]       LAY_XYZ_AMP     = 8'h04;
    localparam logic [7:0]       LAY_DEPTH_XYZ   = 8'h09;
    localparam logic [7:0]       LAY_AXIS_AMP    = 8'h0a;
    localparam logic [7:0]       LAY_TEST        = 8'h0b;
    localparam logic [7:0]       LAY_DEPTH       = 8'h0c;
    localparam logic [15:0]      TEST_CONST      = 16'hbeef;

    // Exposure limits in microseconds
    localparam logic [15:0]      EXPOSURE_MIN_US = 16'd50;
    localparam logic [15:0]      EXPOSURE_MAX_US = 16'd25000;

    // Modulation frequencies in kHz, indexed 0..8
    localparam int unsigned      MOD_ENTRIES     = 9;
    localparam logic [15:0]      MOD_KHZ [MOD_ENTRIES] = '{
        16'd5000, 16'd5630, 16'd6430, 16'd7500, 16'd9000,
        16'd11250, 16'd15000, 16'd22500, 16'd45000
    };

    // Revision fields
    localparam int unsigned      REV_PATCH_LSB   = 0;
    localparam int unsigned      REV_MINOR_LSB   = 6;
    localparam int unsigned      REV_MAJOR_LSB   = 11;

    typedef struct packed {
        logic                    wr;
        logic                    rd;
        logic [15:0]             addr;
        logic [15:0]             wdata;
    } reg_req_t;

    typedef struct packed {
        logic                    calib_busy;
        logic                    led_sens_err;
        logic                    main_sens_err;
        logic                    calib_missing;
        logic                    led_overtemp;
        logic                    base_sens_err;
    } health_t;

    typedef struct packed {
        logic [7:0]              layout;
        logic [15:0]             exposure_us;
        logic [15:0]             mod_khz;
        logic                    mod_valid;
        logic [15:0]             rate;
        logic [15:0]             lens;
    } capture_cfg_t;

endpackage : cam_regs_pkg

/* rtl/layout_decode.sv */
`timescale 1ns/100ps
module layout_decode
    import cam_regs_pkg::*;
(
    input  wire logic [7:0]  i_code,
    output logic      [2:0]  o_channels,
    output logic             o_has_depth,
    output logic             o_has_amp,
    output logic             o_has_xyz,
    output logic             o_axis_only,
    output logic             o_test,
    output logic             o_valid
);

    always_comb begin
        o_channels  = 3'd0;
        o_has_depth = 1'b0;
        o_has_amp   = 1'b0;
        o_has_xyz   = 1'b0;
        o_axis_only = 1'b0;
        o_test      = 1'b0;
        o_valid     = 1'b1;
        case (i_code)
            LAY_DEPTH_AMP: begin
                o_channels  = 3'd2;
                o_has_depth = 1'b1;
                o_has_amp   = 1'b1;
            end
            LAY_XYZ: begin
                o_channels = 3'd3;
                o_has_xyz  = 1'b1;
            end
            LAY_XYZ_AMP: begin
                o_channels = 3'd4;
                o_has_xyz  = 1'b1;
                o_has_amp  = 1'b1;
            end
            LAY_DEPTH_XYZ: begin
                o_channels  = 3'd4;
                o_has_depth = 1'b1;
                o_has_xyz   = 1'b1;
            end
            LAY_AXIS_AMP: begin
                o_channels  = 3'd2;
                o_axis_only = 1'b1;
                o_has_amp   = 1'b1;
            end
            LAY_TEST: begin
                o_channels = 3'd4;
                o_test     = 1'b1;
            end
            LAY_DEPTH: begin
                o_channels  = 3'd1;
                o_has_depth = 1'b1;
            end
            default: o_valid = 1'b0;
        endcase
    end

endmodule : layout_decode

/* rtl/depth_camera_general_regs.sv */
`timescale 1ns/100ps
module depth_camera_general_regs
    import cam_regs_pkg::*;
#(
    parameter logic [15:0] HW_ID       = 16'h1234, // Arbitrary identity value
    parameter logic [15:0] REVISION    = 16'h0841,
    parameter logic [31:0] SERIAL      = 32'h0000_0001
) (
    input  wire logic          i_ref_clk,
    input  wire logic          i_rst,
    input  wire reg_req_t      i_req,
    output logic      [15:0]   o_rdata,
    output logic               o_rvalid,
    input  wire logic          i_frame_done,
    input  wire logic          i_trigger_ack,
    input  wire logic          i_boot_running,
    input  wire health_t       i_health,
    output logic               o_video_mode,
    output logic               o_trigger_req,
    output logic               o_boot_start,
    output logic               o_boot_keep_net,
    output capture_cfg_t       o_cfg,
    output logic      [2:0]    o_channels,
    output logic               o_test_pattern,
    output logic      [15:0]   o_test_const
);

    logic [15:0] control;
    logic [15:0] next_control;
    logic [15:0] status_sticky;
    logic [15:0] next_status_sticky;
    logic [15:0] layout_reg;
    logic [15:0] next_layout_reg;
    logic [15:0] exposure;
    logic [15:0] next_exposure;
    logic [15:0] mod_index;
    logic [15:0] next_mod_index;
    logic [15:0] rate;
    logic [15:0] next_rate;
    logic [15:0] lens;
    logic [15:0] next_lens;
    logic [15:0] unlock_key;
    logic [15:0] next_unlock_key;
    logic [15:0] tally;
    logic [15:0] next_tally;
    logic        boot_start;
    logic        next_boot_start;
    logic        boot_keep_net;
    logic        next_boot_keep_net;
    logic [15:0] rdata;
    logic [15:0] next_rdata;
    logic        rvalid;
    logic        next_rvalid;
    logic [15:0] status_word;
    logic [15:0] mod_khz;
    logic        mod_valid;
    logic        key_ok;
    logic        wr_ctl;
    logic [7:0]  layout_code;

    assign wr_ctl      = i_req.wr && (i_req.addr == OFS_CONTROL);
    assign key_ok      = (unlock_key == BOOT_KEY);
    assign layout_code = layout_reg[LAYOUT_LSB +: LAYOUT_W];

    // Live sensor-fault inputs are ORed with their latched flags so a clear never hides a standing fault
    always_comb begin
        status_word                  = status_sticky;
        status_word[ST_BOOTLOADER]   = i_boot_running;
        status_word[ST_CALIB_BUSY]   = i_health.calib_busy;
        status_word[ST_CALIB_MISS]   = i_health.calib_missing;
        status_word[ST_LED_OVERTEMP] = i_health.led_overtemp;
        status_word[ST_LED_SENS]     = status_sticky[ST_LED_SENS] | i_health.led_sens_err;
        status_word[ST_MAIN_SENS]    = status_sticky[ST_MAIN_SENS] | i_health.main_sens_err;
        status_word[ST_BASE_SENS]    = status_sticky[ST_BASE_SENS] | i_health.base_sens_err;
    end

    always_comb begin
        mod_khz   = 16'd0;
        mod_valid = 1'b0;
        if (mod_index < 16'(MOD_ENTRIES)) begin
            mod_khz   = MOD_KHZ[mod_index[3:0]];
            mod_valid = 1'b1;
        end
    end

    always_comb begin
        next_control       = control;
        next_boot_start    = 1'b0;
        next_boot_keep_net = 1'b0;
        next_unlock_key    = unlock_key;
        next_status_sticky = status_sticky;
        if (control[CTL_TRIGGER] && i_trigger_ack) begin
            next_control[CTL_TRIGGER] = 1'b0;
        end
        if (i_req.wr && (i_req.addr == OFS_UNLOCK)) begin
            next_unlock_key = i_req.wdata;
        end
        if (wr_ctl) begin
            next_control[CTL_VIDEO] = i_req.wdata[CTL_VIDEO];
            // Trigger only latches in manual mode, so a video-mode trigger is dropped
            if (i_req.wdata[CTL_TRIGGER] && !i_req.wdata[CTL_VIDEO]) begin
                next_control[CTL_TRIGGER] = 1'b1;
            end
            if (i_req.wdata[CTL_CLR_STATUS]) begin
                next_status_sticky = 16'h0000;
            end
            if (key_ok && i_req.wdata[CTL_BOOT]) begin
                next_boot_start = 1'b1;
            end
            if (key_ok && i_req.wdata[CTL_BOOT_NET]) begin
                next_boot_start    = 1'b1;
                next_boot_keep_net = 1'b1;
            end
        end
        // Sensor faults are latched after the clear so a same-cycle fault survives
        if (i_health.led_sens_err) begin
            next_status_sticky[ST_LED_SENS] = 1'b1;
        end
        if (i_health.main_sens_err) begin
            next_status_sticky[ST_MAIN_SENS] = 1'b1;
        end
        if (i_health.base_sens_err) begin
            next_status_sticky[ST_BASE_SENS] = 1'b1;
        end
    end

    always_comb begin
        next_layout_reg = layout_reg;
        next_exposure   = exposure;
        next_mod_index  = mod_index;
        next_rate       = rate;
        next_lens       = lens;
        next_tally      = tally;
        if (i_req.wr) begin
            case (i_req.addr)
                OFS_LAYOUT:    next_layout_reg = i_req.wdata;
                OFS_EXPOSURE: begin
                    // Out-of-range exposure writes are ignored, keeping a safe value
                    if (i_req.wdata >= EXPOSURE_MIN_US && i_req.wdata <= EXPOSURE_MAX_US) begin
                        next_exposure = i_req.wdata;
                    end
                end
                OFS_MOD_INDEX: next_mod_index = i_req.wdata;
                OFS_RATE:      next_rate      = i_req.wdata;
                OFS_LENS:      next_lens      = i_req.wdata;
                default:       next_tally     = tally;
            endcase
        end
        if (i_frame_done) begin
            next_tally = 16'(tally + 16'd1);
        end
    end

    always_comb begin
        next_rvalid = i_req.rd;
        next_rdata  = 16'h0000;
        if (i_req.rd) begin
            case (i_req.addr)
                OFS_CONTROL:   next_rdata = control;
                OFS_STATUS:    next_rdata = status_word;
                OFS_LAYOUT:    next_rdata = layout_reg;
                OFS_EXPOSURE:  next_rdata = exposure;
                OFS_HW_ID:     next_rdata = HW_ID;
                OFS_REVISION:  next_rdata = REVISION;
                OFS_MOD_INDEX: next_rdata = mod_index;
                OFS_RATE:      next_rdata = rate;
                OFS_LENS:      next_rdata = lens;
                OFS_SERIAL_LO: next_rdata = SERIAL[15:0];
                OFS_SERIAL_HI: next_rdata = SERIAL[31:16];
                OFS_TALLY:     next_rdata = tally;
                OFS_UNLOCK:    next_rdata = unlock_key;
                default:       next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            control       <= RST_CONTROL;
            status_sticky <= RST_STATUS;
            layout_reg    <= RST_LAYOUT;
            exposure      <= RST_EXPOSURE;
            mod_index     <= RST_MOD_INDEX;
            rate          <= RST_RATE;
            lens          <= RST_LENS;
            unlock_key    <= RST_UNLOCK;
            tally         <= RST_TALLY;
            boot_start    <= 1'b0;
            boot_keep_net <= 1'b0;
            rdata         <= 16'h0000;
            rvalid        <= 1'b0;
        end else begin
            control       <= next_control;
            status_sticky <= next_status_sticky;
            layout_reg    <= next_layout_reg;
            exposure      <= next_exposure;
            mod_index     <= next_mod_index;
            rate          <= next_rate;
            lens          <= next_lens;
            unlock_key    <= next_unlock_key;
            tally         <= next_tally;
            boot_start    <= next_boot_start;
            boot_keep_net <= next_boot_keep_net;
            rdata         <= next_rdata;
            rvalid        <= next_rvalid;
        end
    end

    layout_decode u_layout_decode (
        .i_code      (layout_code),
        .o_channels  (o_channels),
        .o_has_depth (),
        .o_has_amp   (),
        .o_has_xyz   (),
        .o_axis_only (),
        .o_test      (o_test_pattern),
        .o_valid     ()
    );

    assign o_test_const      = TEST_CONST;
    assign o_rdata           = rdata;
    assign o_rvalid          = rvalid;
    assign o_video_mode      = control[CTL_VIDEO];
    assign o_trigger_req     = control[CTL_TRIGGER];
    assign o_boot_start      = boot_start;
    assign o_boot_keep_net   = boot_keep_net;
    // One driver for the whole carrier rather than one per field
    assign o_cfg = '{layout:      layout_code,
                     exposure_us: exposure,
                     mod_khz:     mod_khz,
                     mod_valid:   mod_valid,
                     rate:        rate,
                     lens:        lens};

    property p_video_reset;
        @(posedge i_ref_clk) $fell(i_rst) |-> o_video_mode;
    endproperty
    a_video_reset: assert property (p_video_reset) else $error("video mode not set after reset");

    property p_trigger_clears;
        @(posedge i_ref_clk) disable iff (i_rst)
        (o_trigger_req && i_trigger_ack && !wr_ctl) |=> !o_trigger_req;
    endproperty
    a_trigger_clears: assert property (p_trigger_clears) else $error("trigger did not self-clear");

    property p_trigger_manual_only;
        @(posedge i_ref_clk) disable iff (i_rst) $rose(o_trigger_req) |-> !o_video_mode;
    endproperty
    a_trigger_manual_only: assert property (p_trigger_manual_only) else $error("trigger in video mode");

    property p_clear_status;
        @(posedge i_ref_clk) disable iff (i_rst)
        (wr_ctl && i_req.wdata[CTL_CLR_STATUS] && i_health == '0) |=> status_sticky == 16'h0000;
    endproperty
    a_clear_status: assert property (p_clear_status) else $error("status not cleared");

    property p_boot_needs_key;
        @(posedge i_ref_clk) disable iff (i_rst) o_boot_start |-> $past(key_ok) && $past(wr_ctl);
    endproperty
    a_boot_needs_key: assert property (p_boot_needs_key) else $error("boot without key");

    property p_boot_net;
        @(posedge i_ref_clk) disable iff (i_rst)
        (wr_ctl && key_ok && i_req.wdata[CTL_BOOT_NET]) |=> o_boot_start && o_boot_keep_net;
    endproperty
    a_boot_net: assert property (p_boot_net) else $error("network boot not started");

    property p_status_reset;
        @(posedge i_ref_clk) $fell(i_rst) |-> status_sticky == RST_STATUS;
    endproperty
    a_status_reset: assert property (p_status_reset) else $error("status reset value wrong");

    property p_exposure_range;
        @(posedge i_ref_clk) disable iff (i_rst)
        exposure >= EXPOSURE_MIN_US && exposure <= EXPOSURE_MAX_US;
    endproperty
    a_exposure_range: assert property (p_exposure_range) else $error("exposure out of range");

    property p_tally_step;
        @(posedge i_ref_clk) disable iff (i_rst) i_frame_done |=> tally == $past(tally) + 16'd1;
    endproperty
    a_tally_step: assert property (p_tally_step) else $error("tally did not increment");

    property p_ro_tally;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_req.wr && i_req.addr == OFS_TALLY && !i_frame_done) |=> $stable(tally);
    endproperty
    a_ro_tally: assert property (p_ro_tally) else $error("read-only tally changed by write");

endmodule : depth_camera_general_regs

/* testbench/host_model.sv */
`timescale 1ns/100ps
module host_model
    import cam_regs_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic [15:0] i_rdata,
    input  wire logic        i_rvalid,
    output reg_req_t         o_req
);
    // Idle bus shows inverted old values so nothing stale passes for a request
    initial o_req = '{wr: 1'b0, rd: 1'b0, addr: 16'hffff, wdata: 16'hffff};

    task automatic put(input logic wr, input logic [15:0] addr, input logic [15:0] data);
        @(posedge i_ref_clk);
        #1 o_req = '{wr: wr, rd: ~wr, addr: addr, wdata: data};
        @(posedge i_ref_clk);
    endtask : put

    task automatic reg_write(input logic [15:0] addr, input logic [15:0] data);
        put(1'b1, addr, data);
        #1 o_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
    endtask : reg_write

    task automatic reg_read(input logic [15:0] addr, output logic [15:0] data);
        put(1'b0, addr, 16'h0000);
        #1 data = (i_rvalid === 1'b1) ? i_rdata : 16'hxxxx;
        o_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 16'hffff};
    endtask : reg_read
endmodule : host_model

/* testbench/depth_camera_general_regs_bench.sv */
`timescale 1ns/100ps
module depth_camera_general_regs_bench;
    import cam_regs_pkg::*;
    logic         i_ref_clk  = 1'b0;
    logic         i_rst      = 1'b1;
    logic         frame_done = 1'b0;
    logic         trig_ack   = 1'b0;
    logic         boot_run   = 1'b0;
    health_t      health     = '0;
    reg_req_t     req;
    logic [15:0]  rdata, tconst, rd;
    logic [2:0]   chans;
    logic         rvalid, video, trig, boot, keep_net, test_pat;
    capture_cfg_t cfg;
    int           n_fail     = 0;
    int           n_tests    = 0;

    always #50 i_ref_clk = ~i_ref_clk;

    host_model host_u (.i_ref_clk(i_ref_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));

    depth_camera_general_regs #(
        .HW_ID(16'h00a5), .SERIAL(32'h5a3c_0001) // Arbitrary identity values
    ) dut_u (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_req(req), .o_rdata(rdata),
        .o_rvalid(rvalid), .i_frame_done(frame_done), .i_trigger_ack(trig_ack),
        .i_boot_running(boot_run), .i_health(health), .o_video_mode(video),
        .o_trigger_req(trig), .o_boot_start(boot), .o_boot_keep_net(keep_net),
        .o_cfg(cfg), .o_channels(chans), .o_test_pattern(test_pat), .o_test_const(tconst));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [15:0] addr, input logic [15:0] exp);
        host_u.reg_read(addr, rd);
        chk(rd, exp);
    endtask : rd_chk

    task automatic t_reset;
        chk(16'(video), 16'h0001);
        rd_chk(OFS_CONTROL, 16'h0001);
        rd_chk(OFS_STATUS, 16'h0040);
        rd_chk(OFS_LAYOUT, 16'h0000);
        rd_chk(OFS_EXPOSURE, 16'h01f4);
        rd_chk(OFS_MOD_INDEX, 16'h08ca);
        rd_chk(OFS_RATE, 16'h0019);
        rd_chk(OFS_LENS, 16'h005a);
        rd_chk(16'h0002, 16'h0000);
    endtask : t_reset

    task automatic t_read_only;
        host_u.reg_write(OFS_STATUS, 16'hffff);
        host_u.reg_write(OFS_REVISION, 16'h0000);
        host_u.reg_write(OFS_SERIAL_LO, 16'hffff);
        host_u.reg_write(OFS_HW_ID, 16'h0000);
        rd_chk(OFS_STATUS, 16'h0040);
        rd_chk(OFS_REVISION, 16'h0841);
        rd_chk(OFS_SERIAL_LO, 16'h0001);
        rd_chk(OFS_SERIAL_HI, 16'h5a3c);
        rd_chk(OFS_HW_ID, 16'h00a5);
        host_u.reg_write(OFS_TALLY, 16'h00ff);
        frame_done = 1'b1;
        repeat (3) @(posedge i_ref_clk);
        #1 frame_done = 1'b0;
        rd_chk(OFS_TALLY, 16'h0003);
    endtask : t_read_only

    task automatic t_status;
        boot_run = 1'b1;
        health.calib_busy = 1'b1;
        health.calib_missing = 1'b1;
        health.led_overtemp = 1'b1;
        rd_chk(OFS_STATUS, 16'h0265);
        boot_run = 1'b0;
        health = '0;
        health.led_sens_err = 1'b1;
        health.main_sens_err = 1'b1;
        health.base_sens_err = 1'b1;
        rd_chk(OFS_STATUS, 16'h4058);
        health = '0;
        host_u.reg_write(OFS_CONTROL, 16'h0040);
        rd_chk(OFS_STATUS, 16'h0000);
    endtask : t_status

    task automatic t_trigger;
        host_u.reg_write(OFS_CONTROL, 16'h0011);
        chk(16'(trig), 16'h0000);
        host_u.reg_write(OFS_CONTROL, 16'h0000);
        chk(16'(video), 16'h0000);
        host_u.reg_write(OFS_CONTROL, 16'h0010);
        chk(16'(trig), 16'h0001);
        rd_chk(OFS_CONTROL, 16'h0010);
        trig_ack = 1'b1;
        @(posedge i_ref_clk);
        #1 trig_ack = 1'b0;
        chk(16'(trig), 16'h0000);
        rd_chk(OFS_CONTROL, 16'h0000);
    endtask : t_trigger

    task automatic t_boot;
        host_u.reg_write(OFS_CONTROL, 16'h1100);
        chk(16'(boot), 16'h0000);
        host_u.reg_write(OFS_UNLOCK, BOOT_KEY);
        host_u.reg_write(OFS_CONTROL, 16'h0100);
        chk({15'h0000, boot}, 16'h0001);
        chk(16'(keep_net), 16'h0000);
        host_u.reg_write(OFS_CONTROL, 16'h1000);
        chk({boot, 14'h0000, keep_net}, 16'h8001);
    endtask : t_boot

    task automatic t_exposure;
        logic [15:0] vals [4] = '{EXPOSURE_MIN_US - 16'h0001, EXPOSURE_MIN_US,
                                  EXPOSURE_MAX_US + 16'h0001, EXPOSURE_MAX_US};
        logic [15:0] exps [4] = '{16'h01f4, EXPOSURE_MIN_US, EXPOSURE_MIN_US, EXPOSURE_MAX_US};
        foreach (vals[i]) begin
            host_u.reg_write(OFS_EXPOSURE, vals[i]);
            chk(cfg.exposure_us, exps[i]);
        end
        rd_chk(OFS_EXPOSURE, EXPOSURE_MAX_US);
    endtask : t_exposure

    task automatic t_layout;
        logic [7:0] codes [7] = '{8'h00, 8'h03, 8'h04, 8'h09, 8'h0a, 8'h0b, 8'h0c};
        logic [2:0] nch [7]   = '{3'd2, 3'd3, 3'd4, 3'd4, 3'd2, 3'd4, 3'd1};
        foreach (codes[i]) begin
            host_u.reg_write(OFS_LAYOUT, {5'h00, codes[i], 3'h0});
            chk(16'(cfg.layout), 16'(codes[i]));
            chk(16'(chans), 16'(nch[i]));
            chk(16'(test_pat), 16'(codes[i] == 8'h0b));
        end
        rd_chk(OFS_LAYOUT, 16'h0060);
        chk(tconst, 16'hbeef);
    endtask : t_layout

    task automatic t_mod_rate;
        int khz [9] = '{5000, 5630, 6430, 7500, 9000, 11250, 15000, 22500, 45000};
        chk(16'(cfg.mod_valid), 16'h0000);
        for (int i = 0; i < 9; i++) begin
            host_u.reg_write(OFS_MOD_INDEX, 16'(i));
            chk(16'(cfg.mod_valid), 16'h0001);
            chk(cfg.mod_khz, 16'(khz[i]));
        end
        host_u.reg_write(OFS_RATE, 16'h001e);
        host_u.reg_write(OFS_LENS, 16'h003c);
        chk(cfg.rate, 16'h001e);
        chk(cfg.lens, 16'h003c);
    endtask : t_mod_rate

    task automatic give_verdict;
        $display("checks %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (5) @(posedge i_ref_clk);
        #1 i_rst = 1'b0;
        t_reset();
        t_read_only();
        t_status();
        t_trigger();
        t_boot();
        t_exposure();
        t_layout();
        t_mod_rate();
        give_verdict();
    end

    // About 120 cycles are needed; allow twenty-five times that
    initial begin
        #(3000 * 100);
        n_fail++;
        give_verdict();
    end
endmodule : depth_camera_general_regs_bench
